// file: core/fcr_ctrl.sv
// What this block does
// - Issue Read Array before reading array again
// - Flag aborted operations for software reissue
// - Chip select 0 only, selects 1 and 2 tied low; shared output enable
// - Reset pin follows supply good, pulses
`timescale 1ns/100ps
`include "fcr_cfg.svh"

module fcr_ctrl (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             irq,
   // System
   input  wire logic        supply_good_signal,
   // Flash pins
   output logic [23:0]      flash_addr,
   output logic [15:0]      flash_dq_out,
   output logic             flash_dq_oe,
   input  wire logic [15:0] flash_dq_in,
   output logic             flash_we_n,
   output logic             flash_oe_n,
   output logic             chip_select_0,
   output logic             chip_select_1,
   output logic             chip_select_2,
   output logic             reset_powerdown_n,
   input  wire logic        completion_output
);
   import fcr_pkg::*;

   fcr_regs_t q;
   fcr_regs_t d;

   logic        a_valid;
   logic        go_wr;
   logic        go_rd;
   logic        go_rst;
   logic [2:0]  ev;
   logic [7:0]  ra;
   logic [31:0] rd_val;
   logic        dev_busy;

   always_comb begin
      d        = q;
      ev       = 3'h0;
      dev_busy = ~q.cmpl_s2;

      // Pin inputs pass two flops before anything looks at them
      d.cmpl_s1 = completion_output;
      d.cmpl_s2 = q.cmpl_s1;
      d.sg_s1   = supply_good_signal;
      d.sg_s2   = q.sg_s1;
      d.dq_s1   = flash_dq_in;
      d.dq_s2   = q.dq_s1;
      // Open drain line idles high; a release after a low means done
      d.cmpl_prev = q.cmpl_s2;

      // Register writes land in the data phase
      go_wr  = 1'b0;
      go_rd  = 1'b0;
      go_rst = 1'b0;
      if (q.ph_wr) begin
         if (q.ph_addr == `FCR_OFF_CTRL) begin
            go_wr  = hwdata[`FCR_CTRL_GO_WRITE];
            go_rd  = hwdata[`FCR_CTRL_GO_READ];
            go_rst = hwdata[`FCR_CTRL_GO_RESET];
            d.hold = hwdata[`FCR_CTRL_HOLD];
            if (hwdata[`FCR_CTRL_ACK_ABRT]) begin
               d.reissue = 1'b0;
            end
         end else if (q.ph_addr == `FCR_OFF_ADDR) begin
            d.addr = hwdata[23:0];
         end else if (q.ph_addr == `FCR_OFF_WDATA) begin
            d.wdata = hwdata[15:0];
         end else if (q.ph_addr == `FCR_OFF_IRQ_MASK) begin
            d.irq_mask = hwdata[2:0];
         end
      end

      // Busy ends as the pin is released after a low: the algorithm ended
      if (q.cmpl_s2 && !q.cmpl_prev && q.rp_n) begin
         ev[`FCR_IRQ_DONE] = 1'b1;
      end
      // Completion pulled low: an erase, program or lock op started,
      // so array reads need the Read Array command first
      if (!q.cmpl_s2 && q.cmpl_prev && q.rp_n) begin
         d.need_ra = 1'b1;
      end

      if (q.cnt != 16'h0000) begin
         d.cnt = q.cnt - 16'h0001;
      end

      case (q.st)
         FCR_IDLE: begin
            if (go_rst) begin
               d.st  = FCR_RST_LOW;
               d.cnt = 16'(`FCR_PLPH_CYC - 1);
            end else if (go_wr && q.rp_n) begin
               d.st     = FCR_WR_SETUP;
               d.fa     = q.addr;
               d.dq_out = q.wdata;
               d.dq_oe  = 1'b1;
               d.cs0_n  = 1'b0;
            end else if (go_rd && q.rp_n) begin
               d.fa    = q.addr;
               d.cs0_n = 1'b0;
               if (q.need_ra) begin
                  // Slip a Read Array write in front of the read
                  d.st      = FCR_WR_SETUP;
                  d.dq_out  = `FCR_READ_ARRAY;
                  d.dq_oe   = 1'b1;
                  d.rd_pend = 1'b1;
               end else begin
                  d.st   = FCR_RD_PULSE;
                  d.oe_n = 1'b0;
                  d.cnt  = 16'(`FCR_ACC_CYC - 1);
               end
            end
         end
         FCR_WR_SETUP: begin
            d.st   = FCR_WR_PULSE;
            d.we_n = 1'b0;
            d.cnt  = 16'(`FCR_WE_CYC - 1);
         end
         FCR_WR_PULSE: begin
            if (q.cnt == 16'h0000) begin
               d.st   = FCR_WR_HOLD;
               d.we_n = 1'b1;
            end
         end
         FCR_WR_HOLD: begin
            d.dq_oe = 1'b0;
            if (q.dq_out == `FCR_READ_ARRAY) begin
               d.need_ra = 1'b0;
            end
            if (q.rd_pend) begin
               d.rd_pend = 1'b0;
               d.st      = FCR_RD_PULSE;
               d.oe_n    = 1'b0;
               d.cnt     = 16'(`FCR_ACC_CYC - 1);
            end else begin
               d.st    = FCR_IDLE;
               d.cs0_n = 1'b1;
               ev[`FCR_IRQ_XFER] = 1'b1;
            end
         end
         FCR_RD_PULSE: begin
            if (q.cnt == 16'h0000) begin
               d.st    = FCR_IDLE;
               d.rdata = q.dq_s2;
               d.oe_n  = 1'b1;
               d.cs0_n = 1'b1;
               ev[`FCR_IRQ_XFER] = 1'b1;
            end
         end
         FCR_RST_LOW: begin
            if (q.cnt == 16'h0000) begin
               d.st  = FCR_RST_REC;
               d.cnt = 16'(`FCR_PHRH_CYC - 1);
            end
         end
         FCR_RST_REC: begin
            // Completion may still read low up to both reset times
            if (q.cnt == 16'h0000) begin
               d.st = FCR_IDLE;
            end
         end
         default: begin
            d.st = FCR_IDLE;
         end
      endcase

      // Reset pin low on supply loss, hold, or a commanded pulse
      d.rp_n = q.sg_s2 && !d.hold && (d.st != FCR_RST_LOW);
      if (!d.rp_n && q.rp_n && dev_busy) begin
         // An operation was cut short and must be issued again
         d.reissue          = 1'b1;
         ev[`FCR_IRQ_ABORT] = 1'b1;
      end
      if (!q.rp_n) begin
         // Device leaves reset in read-array mode
         d.need_ra = 1'b0;
      end

      // AHB address phase
      a_valid = hsel && htrans[1] && hready;
      ra      = haddr[7:0];
      rd_val  = 32'h0000_0000;
      if (ra == `FCR_OFF_CTRL) begin
         rd_val[`FCR_CTRL_HOLD] = q.hold;
      end else if (ra == `FCR_OFF_ADDR) begin
         rd_val[23:0] = q.addr;
      end else if (ra == `FCR_OFF_WDATA) begin
         rd_val[15:0] = q.wdata;
      end else if (ra == `FCR_OFF_RDATA) begin
         rd_val[15:0] = q.rdata;
      end else if (ra == `FCR_OFF_STATUS) begin
         rd_val[`FCR_ST_BUSY]     = (q.st != FCR_IDLE);
         rd_val[`FCR_ST_DEV_BUSY] = dev_busy;
         rd_val[`FCR_ST_NEED_RA]  = q.need_ra;
         rd_val[`FCR_ST_REISSUE]  = q.reissue;
         rd_val[`FCR_ST_SUPPLY]   = q.sg_s2;
      end else if (ra == `FCR_OFF_IRQ_STAT) begin
         rd_val[2:0] = q.irq_stat;
      end else if (ra == `FCR_OFF_IRQ_MASK) begin
         rd_val[2:0] = q.irq_mask;
      end
      d.ph_wr   = a_valid && hwrite;
      d.ph_addr = ra;
      if (a_valid && !hwrite) begin
         d.hrdata = rd_val;
      end

      // Read clears; an event in the same cycle still sticks
      if (a_valid && !hwrite && ra == `FCR_OFF_IRQ_STAT) begin
         d.irq_stat = ev;
      end else begin
         d.irq_stat = q.irq_stat | ev;
      end
      d.irq = |(d.irq_stat & d.irq_mask);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q          <= '0;
         q.st       <= FCR_IDLE;
         q.we_n     <= 1'b1;
         q.oe_n     <= 1'b1;
         q.cs0_n    <= 1'b1;
         q.cmpl_s1  <= 1'b1;
         q.cmpl_s2  <= 1'b1;
         q.cmpl_prev <= 1'b1;
         q.addr     <= `FCR_RST_ADDR;
         q.wdata    <= `FCR_RST_WDATA;
         q.irq_mask <= `FCR_RST_MASK;
      end else begin
         q <= d;
      end
   end

   // System reset also pulls the device reset low, until supply good has passed both sync flops
   assign reset_powerdown_n = q.rp_n;
   assign hreadyout         = 1'b1;
   assign hresp             = 1'b0;
   assign hrdata            = q.hrdata;
   assign irq               = q.irq;
   assign flash_addr        = q.fa;
   assign flash_dq_out      = q.dq_out;
   assign flash_dq_oe       = q.dq_oe;
   assign flash_we_n        = q.we_n;
   assign flash_oe_n        = q.oe_n;
   assign chip_select_0     = q.cs0_n;
   assign chip_select_1     = 1'b0;
   assign chip_select_2     = 1'b0;

endmodule // fcr_ctrl

// file: core/fcr_cfg.svh
`ifndef FCR_CFG_SVH
`define FCR_CFG_SVH

// Register byte offsets, haddr[7:0]
`define FCR_OFF_CTRL      8'h00
`define FCR_OFF_ADDR      8'h04
`define FCR_OFF_WDATA     8'h08
`define FCR_OFF_RDATA     8'h0c
`define FCR_OFF_STATUS    8'h10
`define FCR_OFF_IRQ_STAT  8'h14
`define FCR_OFF_IRQ_MASK  8'h18

// Control bit positions
`define FCR_CTRL_GO_WRITE 0
`define FCR_CTRL_GO_READ  1
`define FCR_CTRL_GO_RESET 2
`define FCR_CTRL_HOLD     3
`define FCR_CTRL_ACK_ABRT 4

// Status bit positions
`define FCR_ST_BUSY       0
`define FCR_ST_DEV_BUSY   1
`define FCR_ST_NEED_RA    2
`define FCR_ST_REISSUE    3
`define FCR_ST_SUPPLY     4

// Interrupt bit positions
`define FCR_IRQ_XFER      0
`define FCR_IRQ_DONE      1
`define FCR_IRQ_ABORT     2

// Reset values and the Read Array command
`define FCR_RST_ADDR      24'h00_0000
`define FCR_RST_WDATA     16'h0000
`define FCR_RST_MASK      3'h0
`define FCR_READ_ARRAY    16'h00ff

// Timing
`define FCR_CLK_MHZ       10
`define FCR_T_WE_NS       70
`define FCR_T_ACC_NS      150
`define FCR_T_PLPH_NS     35000
`define FCR_T_PHRH_NS     210
`define FCR_SYNC_CYC      2
`define FCR_CYC_UP(ns)    ((((ns) * `FCR_CLK_MHZ) + 999) / 1000)
`define FCR_WE_CYC        `FCR_CYC_UP(`FCR_T_WE_NS)
`define FCR_ACC_CYC       (`FCR_CYC_UP(`FCR_T_ACC_NS) + `FCR_SYNC_CYC)
`define FCR_PLPH_CYC      `FCR_CYC_UP(`FCR_T_PLPH_NS)
`define FCR_PHRH_CYC      `FCR_CYC_UP(`FCR_T_PHRH_NS)

`endif

// file: core/fcr_pkg.sv
package fcr_pkg;

   typedef enum logic [2:0] {
      FCR_IDLE     = 3'b000,
      FCR_WR_SETUP = 3'b001,
      FCR_WR_PULSE = 3'b010,
      FCR_WR_HOLD  = 3'b011,
      FCR_RD_PULSE = 3'b100,
      FCR_RST_LOW  = 3'b101,
      FCR_RST_REC  = 3'b110
   } fcr_state_t;

   typedef struct packed {
      fcr_state_t  st;
      logic [15:0] cnt;
      logic        rp_n;
      logic        we_n;
      logic        oe_n;
      logic        cs0_n;
      logic        dq_oe;
      logic [15:0] dq_out;
      logic [23:0] fa;
      logic [23:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic        hold;
      logic        need_ra;
      logic        reissue;
      logic        rd_pend;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      logic        cmpl_s1;
      logic        cmpl_s2;
      logic        cmpl_prev;
      logic        sg_s1;
      logic        sg_s2;
      logic [15:0] dq_s1;
      logic [15:0] dq_s2;
      logic [31:0] hrdata;
      logic        ph_wr;
      logic [7:0]  ph_addr;
      logic        irq;
   } fcr_regs_t;

endpackage

// file: testbench/fcr_ctrl_assertions.sv
`timescale 1ns/100ps

module fcr_ctrl_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Flash side
   input wire logic        supply_good_signal,
   input wire logic [15:0] flash_dq_out,
   input wire logic        flash_dq_oe,
   input wire logic        flash_we_n,
   input wire logic        flash_oe_n,
   input wire logic        chip_select_0,
   input wire logic        reset_powerdown_n,
   input wire logic        completion_output
);
   logic ra_need_q;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Busy seen and no Read Array written since; reset also restores it
   always_ff @(posedge clk)
      if (rst || !reset_powerdown_n ||
          (!flash_we_n && flash_dq_out == 16'h00ff))
         ra_need_q <= 1'b0;
      else if (!completion_output)
         ra_need_q <= 1'b1;

   AST_READ_AFTER_RA: assert property ($fell(flash_oe_n) |-> !ra_need_q)
      else $error("array read without Read Array");
   AST_OE_SEL: assert property (!flash_oe_n |-> !chip_select_0)
      else $error("output enable without select");
   AST_WE_SEL: assert property (!flash_we_n |-> !chip_select_0 && flash_dq_oe)
      else $error("write strobe without select or data");
   AST_NO_FIGHT: assert property (flash_dq_oe |-> flash_oe_n)
      else $error("data bus driven during read");
   AST_SUPPLY_RST: assert property (!supply_good_signal [*4] |-> !reset_powerdown_n)
      else $error("reset pin high while supply bad");
   AST_NO_WR_RST: assert property (!reset_powerdown_n |-> flash_we_n && flash_oe_n)
      else $error("access while reset pin low");
   AST_RST_LONG: assert property ($fell(reset_powerdown_n) |=> !reset_powerdown_n [*8])
      else $error("reset pulse too short");
   AST_WE_ONE: assert property ($fell(flash_we_n) |=> $rose(flash_we_n) ##1 !flash_dq_oe)
      else $error("write pulse shape wrong");

   CVR_WRITE: cover property ($rose(flash_we_n));
   CVR_READ: cover property ($rose(flash_oe_n));
   CVR_ABORT: cover property ($fell(reset_powerdown_n) && !completion_output);
endmodule // fcr_ctrl_chk

bind fcr_ctrl fcr_ctrl_chk i_chk (.*);

// file: testbench/fcr_flash_model.sv
`timescale 1ns/100ps

module fcr_flash_model #(
   parameter int BUSY = 40
) (
   // Timebase
   input wire logic        clk,
   // Control pins
   input wire logic        chip_select_0,
   input wire logic        flash_we_n,
   input wire logic        flash_oe_n,
   input wire logic        reset_powerdown_n,
   // Data bus
   input wire logic        flash_dq_oe,
   input wire logic [15:0] flash_dq_out,
   output logic [15:0]     flash_dq_in,
   // Open drain, pulled up
   output logic            completion_output
);
   int          cnt = 0;
   logic        we_q = 1'b1;
   logic        st_mode = 1'b0;
   logic        perr = 1'b0;
   logic [15:0] mem = 16'h0000;
   logic [15:0] last = 16'h0000;
   logic [15:0] rd;

   assign rd = st_mode ? {8'h00, cnt == 0, 2'h0, perr, 4'h0} : mem;
   assign completion_output = (cnt == 0);
   // Released bus shows the inverse, so a stale read cannot pass
   assign flash_dq_in = flash_dq_oe ? flash_dq_out :
                        (!chip_select_0 && !flash_oe_n) ? rd : ~last;

   always @(posedge clk) begin
      we_q <= flash_we_n;
      if (!chip_select_0 && !flash_oe_n)
         last <= rd;
      if (cnt != 0)
         cnt <= cnt - 1;
      if (!reset_powerdown_n) begin
         st_mode <= 1'b0;
         perr <= 1'b0;
         if (cnt > 20)
            cnt <= 20;
      end else if (flash_we_n && !we_q && !chip_select_0) begin
         if (flash_dq_out == 16'h00ff)
            st_mode <= 1'b0;
         else if (flash_dq_out == 16'h0050)
            perr <= 1'b0;
         else if (cnt == 0) begin
            cnt <= BUSY;
            st_mode <= 1'b1;
            mem <= flash_dq_out;
            perr <= perr | (flash_dq_out == 16'hbad0);
         end
      end
   end
endmodule // fcr_flash_model

// file: testbench/test_flash_completion_and_reset_control.sv
`timescale 1ns/100ps
`include "fcr_cfg.svh"

module test_flash_completion_and_reset_control;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        supply_good_signal = 1'b1;
   logic        hreadyout, hresp, irq, flash_dq_oe, flash_we_n, flash_oe_n;
   logic        chip_select_0, reset_powerdown_n, completion_output;
   logic        chip_select_1, chip_select_2;
   logic [23:0] flash_addr;
   logic [15:0] flash_dq_out, flash_dq_in;
   logic [31:0] hrdata, v;
   int          errors = 0;
   int          total_checks = 0;
   int          cyc = 0;

   fcr_ctrl i_dut (.*, .hready(hreadyout));
   fcr_flash_model i_flash (.*);

   always #50 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One single AHB transfer; read data lands in v
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask

   // Settle first: device busy shows only after the sync delay
   task automatic idle();
      repeat (8) @(posedge clk);
      v = 32'h1;
      for (int i = 0; i < 999 && v[1:0] !== 2'h0; i++)
         bus(1'b0, `FCR_OFF_STATUS, 32'h0);
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         summarize();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      bus(1'b0, `FCR_OFF_IRQ_MASK, 32'h0);
      chk(v, 32'h0);
      bus(1'b1, `FCR_OFF_ADDR, 32'hffff_ffff);
      bus(1'b0, `FCR_OFF_ADDR, 32'h0);
      chk(v, 32'h00ff_ffff);
      bus(1'b0, 8'h1c, 32'h0);
      chk(v, 32'h0);
      bus(1'b0, `FCR_OFF_STATUS, 32'h0);
      chk(v, 32'h10);
      bus(1'b1, `FCR_OFF_IRQ_MASK, 32'h2);
      bus(1'b1, `FCR_OFF_ADDR, 32'h10);
      bus(1'b1, `FCR_OFF_WDATA, 32'h1234);
      bus(1'b1, `FCR_OFF_CTRL, 32'h1);
      idle();
      chk({31'h0, irq}, 32'h1);
      chk({8'h0, flash_addr}, 32'h10);
      chk({29'h0, hresp, chip_select_1, chip_select_2}, 32'h0);
      bus(1'b0, `FCR_OFF_STATUS, 32'h0);
      chk(v, 32'h14);
      bus(1'b0, `FCR_OFF_IRQ_STAT, 32'h0);
      chk(v, 32'h3);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, `FCR_OFF_CTRL, 32'h2);
      idle();
      bus(1'b0, `FCR_OFF_RDATA, 32'h0);
      chk(v, 32'h1234);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, `FCR_OFF_CTRL, 32'h1);
      repeat (10) @(posedge clk);
      bus(1'b1, `FCR_OFF_CTRL, 32'h4);
      idle();
      bus(1'b0, `FCR_OFF_STATUS, 32'h0);
      chk(v, 32'h18);
      bus(1'b0, `FCR_OFF_IRQ_STAT, 32'h0);
      chk(v & 32'h4, 32'h4);
      bus(1'b1, `FCR_OFF_CTRL, 32'h10);
      bus(1'b0, `FCR_OFF_STATUS, 32'h0);
      chk(v, 32'h10);
      supply_good_signal <= 1'b0;
      repeat (10) @(posedge clk);
      chk({31'h0, reset_powerdown_n}, 32'h0);
      bus(1'b1, `FCR_OFF_CTRL, 32'h1);
      repeat (5) @(posedge clk);
      chk({31'h0, flash_we_n}, 32'h1);
      supply_good_signal <= 1'b1;
      bus(1'b1, `FCR_OFF_CTRL, 32'h8);
      repeat (10) @(posedge clk);
      chk({31'h0, reset_powerdown_n}, 32'h0);
      bus(1'b1, `FCR_OFF_CTRL, 32'h0);
      repeat (6) @(posedge clk);
      chk({31'h0, reset_powerdown_n}, 32'h1);
      summarize();
   end
endmodule // test_flash_completion_and_reset_control
